/* cioc_pkg.sv */
/*
 * Shared constants and types of the core I/O control register bank.
 * Assumes a 32-bit classic Wishbone bus with 8-bit registers in the low lane.
 */
package cioc_pkg;
    // ==========================================================
    // Register indices; byte address is four times the index.
    localparam int         ADR_W     = 10;
    localparam logic [7:0] IDX_SP    = 8'h02;
    localparam logic [7:0] IDX_CLKMD = 8'h03;
    localparam logic [7:0] IDX_INTEN = 8'h04;
    localparam logic [7:0] IDX_INTRQ = 8'h05;
    localparam logic [7:0] IDX_WIDE_TIMER_CONFIG  = 8'h06;
    localparam logic [7:0] IDX_CNTL  = 8'h20;
    localparam logic [7:0] IDX_CNTH  = 8'h21;
    // ==========================================================
    // Reset values.
    localparam logic [7:0]  SP_RST    = 8'h00;
    localparam logic [7:0]  CLKMD_RST = 8'hf6;
    localparam logic [7:0]  INTEN_RST = 8'h00;
    localparam logic [7:0]  INTRQ_RST = 8'h00;
    localparam logic [7:0]  WIDE_TIMER_CONFIG_RST  = 8'h00;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    // ==========================================================
    // Clock mode fields.
    localparam int CK_SEL_LSB = 5;
    localparam int FAST_EN    = 4;
    localparam int CK_TYPE    = 3;
    localparam int SLOW_EN    = 2;
    localparam int WDT_EN     = 1;
    localparam int RST_PIN    = 0;
    // ==========================================================
    // Interrupt bit positions; reserved bits are 7 and 3.
    localparam int         IRQ_T2   = 6;
    localparam int         IRQ_PWM  = 5;
    localparam int         IRQ_CMP  = 4;
    localparam int         IRQ_T16  = 2;
    localparam int         IRQ_PA4  = 1;
    localparam int         IRQ_PA0  = 0;
    localparam logic [7:0] IRQ_IMPL = 8'h77;
    // ==========================================================
    // Wide timer fields and clock source codes.
    localparam int         T16_SRC_LSB = 5;
    localparam int         T16_DIV_LSB = 3;
    localparam logic [2:0] T16_OFF     = 3'h0;
    localparam logic [2:0] T16_SYS     = 3'h1;
    localparam logic [2:0] T16_PA4     = 3'h3;
    localparam logic [2:0] T16_FAST    = 3'h4;
    localparam logic [2:0] T16_XTAL    = 3'h5;
    localparam logic [2:0] T16_SLOW    = 3'h6;
    localparam logic [2:0] T16_PA0     = 3'h7;
    localparam logic [2:0] T16_NOBIT   = 3'h6;

    typedef struct packed {
        logic t2;
        logic pwm;
        logic cmp;
    } cioc_evt_s;

    typedef struct packed {
        logic fast_en;
        logic slow_en;
        logic wdt_en;
        logic ext_rst_sel;
    } cioc_osc_s;

    typedef struct packed {
        logic       slow_src;
        logic [6:0] div;
    } cioc_clk_s;
endpackage

/* cioc_regs.sv */
/*
 * Core I/O control register bank: stack pointer, clock mode, interrupt
 * enable and request, wide timer configuration and the wide timer itself.
 * Assumes a classic Wishbone master on sys_clk and event pulses from
 * on-chip units on the same clock; pins and oscillator taps are asynchronous.
 */
// Implementation choice: the Wishbone slave port.
module cioc_regs
    import cioc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              core_sp_load,
    input  wire logic [7:0]        core_sp_val,
    input  wire cioc_evt_s         unit_evt,
    input  wire logic              port_a_pin_zero,
    input  wire logic              port_a_pin_four,
    input  wire logic              fast_rc_osc,
    input  wire logic              slow_rc_osc,
    input  wire logic              crystal_osc,
    output logic      [7:0]        stack_ptr,
    output cioc_osc_s              osc_ctrl,
    output cioc_clk_s              sys_clk_sel,
    output logic      [15:0]       wide_count,
    output logic                   irq
);
    // ==========================================================
    // Registers.
    logic [7:0]  sp_ff;
    logic [7:0]  clkmd_ff;
    logic [7:0]  inten_ff;
    logic [7:0]  intrq_ff;
    logic [7:0]  wide_timer_config_ff;
    logic [15:0] cnt_ff;
    logic [5:0]  pdiv_ff;
    logic        ack_ff;
    logic [31:0] dat_ff;
    logic        irq_ff;
    cioc_osc_s   osc_ff;
    cioc_clk_s   clk_ff;
    logic [4:0]  s1_ff;
    logic [4:0]  s2_ff;
    logic [4:0]  s3_ff;
    logic [4:0]  filt_ff;

    // ==========================================================
    // Bus decode.
    wire       req    = wb_cyc_i & wb_stb_i;
    wire [7:0] idx    = wb_adr_i[ADR_W-1:2];
    wire       wr     = req & wb_we_i & ack_ff & wb_sel_i[0];
    wire [7:0] wd     = wb_dat_i[7:0];
    wire       hit_sp = idx == IDX_SP;
    wire       hit_ck = idx == IDX_CLKMD;
    wire       hit_en = idx == IDX_INTEN;
    wire       hit_rq = idx == IDX_INTRQ;
    wire       hit_tm = idx == IDX_WIDE_TIMER_CONFIG;
    wire       hit_cl = idx == IDX_CNTL;
    wire       hit_ch = idx == IDX_CNTH;
    wire [7:0] rd8    = hit_sp ? sp_ff :
                        hit_ck ? clkmd_ff :
                        hit_en ? inten_ff :
                        hit_rq ? intrq_ff :
                        hit_tm ? wide_timer_config_ff :
                        hit_cl ? cnt_ff[7:0] :
                        hit_ch ? cnt_ff[15:8] : 8'h00;

    // ==========================================================
    // Pin and oscillator synchronisers with agreement filter.
    wire [4:0] pins = {crystal_osc, slow_rc_osc, fast_rc_osc, port_a_pin_four, port_a_pin_zero};
    wire [4:0] nxt_filt = (s2_ff & s3_ff) | (filt_ff & (s2_ff | s3_ff));
    wire [4:0] rise = nxt_filt & ~filt_ff;
    wire [4:0] fall = ~nxt_filt & filt_ff;
    wire [4:0] chg  = nxt_filt ^ filt_ff;

    // ==========================================================
    // Next register values.
    wire [7:0] nxt_sp    = (wr & hit_sp) ? wd : core_sp_load ? core_sp_val : sp_ff;
    wire [7:0] nxt_clkmd = (wr & hit_ck) ? wd : clkmd_ff;
    wire [7:0] nxt_inten = (wr & hit_en) ? (wd & IRQ_IMPL) : inten_ff;
    wire [7:0] nxt_wide_timer_config  = (wr & hit_tm) ? wd : wide_timer_config_ff;
    wire [7:0] rq_clr    = (wr & hit_rq) ? wd : 8'h00;

    // ==========================================================
    // Wide timer.
    wire [2:0] src   = wide_timer_config_ff[T16_SRC_LSB+2:T16_SRC_LSB];
    wire [1:0] psel  = wide_timer_config_ff[T16_DIV_LSB+1:T16_DIV_LSB];
    wire [2:0] isel  = wide_timer_config_ff[2:0];
    wire       src_tick = (src == T16_SYS)  ? 1'b1 :
                          (src == T16_PA4)  ? fall[1] :
                          (src == T16_FAST) ? rise[2] :
                          (src == T16_SLOW) ? rise[3] :
                          (src == T16_XTAL) ? rise[4] :
                          (src == T16_PA0)  ? fall[0] : 1'b0;
    wire [5:0] pmask = (psel == 2'h0) ? 6'h00 :
                       (psel == 2'h1) ? 6'h03 :
                       (psel == 2'h2) ? 6'h0f : 6'h3f;
    wire        cnt_tick = src_tick & ((pdiv_ff & pmask) == pmask);
    wire [5:0]  nxt_pdiv = src_tick ? pdiv_ff + 6'h01 : pdiv_ff;
    wire [15:0] nxt_cnt  = cnt_tick ? cnt_ff + 16'h0001 : cnt_ff;
    wire [3:0]  bsel     = {1'b1, isel};
    wire        t16_evt  = cnt_tick & (isel != T16_NOBIT) & (cnt_ff[bsel] ^ nxt_cnt[bsel]);

    // ==========================================================
    // Interrupt requests; a set in the clearing cycle wins.
    logic [7:0] evt;
    always_comb begin
        evt          = 8'h00;
        evt[IRQ_T2]  = unit_evt.t2;
        evt[IRQ_PWM] = unit_evt.pwm;
        evt[IRQ_CMP] = unit_evt.cmp;
        evt[IRQ_T16] = t16_evt;
        evt[IRQ_PA4] = chg[1];
        evt[IRQ_PA0] = chg[0];
    end
    wire [7:0] nxt_intrq = ((intrq_ff & ~rq_clr) | evt) & IRQ_IMPL;
    wire       nxt_irq   = |(nxt_intrq & nxt_inten);

    // ==========================================================
    // System clock selection decode.
    cioc_clk_s nxt_clk;
    always_comb begin
        nxt_clk = clk_ff;
        case ({clkmd_ff[CK_TYPE], clkmd_ff[CK_SEL_LSB+2:CK_SEL_LSB]})
            4'h0: nxt_clk = '{slow_src: 1'b0, div: 7'h04};
            4'h1: nxt_clk = '{slow_src: 1'b0, div: 7'h02};
            4'h6: nxt_clk = '{slow_src: 1'b1, div: 7'h04};
            4'h7: nxt_clk = '{slow_src: 1'b1, div: 7'h01};
            4'h8: nxt_clk = '{slow_src: 1'b0, div: 7'h10};
            4'h9: nxt_clk = '{slow_src: 1'b0, div: 7'h08};
            4'ha: nxt_clk = '{slow_src: 1'b1, div: 7'h10};
            4'hb: nxt_clk = '{slow_src: 1'b0, div: 7'h20};
            4'hc: nxt_clk = '{slow_src: 1'b0, div: 7'h40};
            default: nxt_clk = clk_ff;
        endcase
    end
    cioc_osc_s nxt_osc;
    assign nxt_osc.fast_en     = clkmd_ff[FAST_EN];
    assign nxt_osc.slow_en     = clkmd_ff[SLOW_EN];
    assign nxt_osc.wdt_en      = clkmd_ff[WDT_EN] & clkmd_ff[SLOW_EN];
    assign nxt_osc.ext_rst_sel = clkmd_ff[RST_PIN];

    // ==========================================================
    // Flip-flops.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sp_ff    <= SP_RST;
            clkmd_ff <= CLKMD_RST;
            inten_ff <= INTEN_RST;
            intrq_ff <= INTRQ_RST;
            wide_timer_config_ff  <= WIDE_TIMER_CONFIG_RST;
            cnt_ff   <= CNT_RST;
            pdiv_ff  <= 6'h00;
        end else begin
            sp_ff    <= nxt_sp;
            clkmd_ff <= nxt_clkmd;
            inten_ff <= nxt_inten;
            intrq_ff <= nxt_intrq;
            wide_timer_config_ff  <= nxt_wide_timer_config;
            cnt_ff   <= nxt_cnt;
            pdiv_ff  <= nxt_pdiv;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
            irq_ff <= 1'b0;
            osc_ff <= 4'he;
            clk_ff <= '{slow_src: 1'b1, div: 7'h01};
        end else begin
            ack_ff <= req & ~ack_ff;
            dat_ff <= (req & ~ack_ff) ? {24'h00_0000, rd8} : dat_ff;
            irq_ff <= nxt_irq;
            osc_ff <= nxt_osc;
            clk_ff <= nxt_clk;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_ff   <= 5'h00;
            s2_ff   <= 5'h00;
            s3_ff   <= 5'h00;
            filt_ff <= 5'h00;
        end else begin
            s1_ff   <= pins;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            filt_ff <= nxt_filt;
        end
    end

    assign wb_dat_o    = dat_ff;
    assign wb_ack_o    = ack_ff;
    assign stack_ptr   = sp_ff;
    assign osc_ctrl    = osc_ff;
    assign sys_clk_sel = clk_ff;
    assign wide_count  = cnt_ff;
    assign irq         = irq_ff;

    // ==========================================================
    // Checks.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence sys_div1_s;
        src == T16_SYS && psel == 2'h0;
    endsequence
    sequence bit8_wrap_s;
        sys_div1_s and (isel == 3'h0 && cnt_ff[7:0] == 8'hff);
    endsequence

    sp_write_a: assert property (wr && hit_sp |=> sp_ff == $past(wd))
        else $error("stack pointer write lost");
    sp_read_a: assert property (req && !ack_ff && !wb_we_i && hit_sp |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(sp_ff)})
        else $error("stack pointer read wrong");
    ck_slow_a: assert property (clkmd_ff[7:3] == 5'h1e |=> sys_clk_sel.slow_src && sys_clk_sel.div == 7'h01)
        else $error("slow clock select wrong");
    ck_type1_a: assert property (clkmd_ff[7:3] == 5'h09 |=> sys_clk_sel == '{slow_src: 1'b1, div: 7'h10})
        else $error("type one select wrong");
    fast_en_a: assert property (clkmd_ff[FAST_EN] |=> osc_ctrl.fast_en)
        else $error("fast oscillator enable wrong");
    wdt_off_a: assert property (!clkmd_ff[SLOW_EN] |=> !osc_ctrl.wdt_en && !osc_ctrl.slow_en)
        else $error("watchdog not off with slow oscillator");
    wdt_on_a: assert property (clkmd_ff[WDT_EN] && clkmd_ff[SLOW_EN] |=> osc_ctrl.wdt_en)
        else $error("watchdog enable wrong");
    rst_pin_a: assert property (clkmd_ff[RST_PIN] |=> osc_ctrl.ext_rst_sel)
        else $error("reset pin select wrong");
    irq_out_a: assert property (irq == |(intrq_ff & inten_ff & IRQ_IMPL))
        else $error("interrupt output mismatch");
    req_set_a: assert property (unit_evt.t2 |=> intrq_ff[IRQ_T2])
        else $error("request not set");
    req_hold_a: assert property (intrq_ff[IRQ_CMP] && !(wr && hit_rq && wd[IRQ_CMP]) |=> intrq_ff[IRQ_CMP])
        else $error("request dropped");
    req_rsvd_a: assert property (intrq_ff[7] == 1'b0 && intrq_ff[3] == 1'b0)
        else $error("reserved request bit set");
    cnt_stop_a: assert property (src == T16_OFF |=> $stable(cnt_ff))
        else $error("counter moved while disabled");
    cnt_step_a: assert property (sys_div1_s |=> cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("counter did not step");
    div4_a: assert property (src == T16_SYS && psel == 2'h1 && pdiv_ff[1:0] != 2'h3 |=> $stable(cnt_ff))
        else $error("pre-divider by four wrong");
    t16_evt_a: assert property (bit8_wrap_s |=> intrq_ff[IRQ_T16])
        else $error("timer event missing");
endmodule

/* cioc_tb.sv */
/*
 * Self-checking testbench of the core I/O control register bank.
 * Assumes the cioc_regs module and the cioc_pkg package compile before it.
 */
module testbench
    import cioc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals.
    logic             sys_clk = 1'b0;
    logic             reset_n = 1'b0;
    logic             wb_cyc_i = 1'b0;
    logic             wb_stb_i = 1'b0;
    logic             wb_we_i = 1'b0;
    logic [ADR_W-1:0] wb_adr_i = '0;
    logic [3:0]       wb_sel_i = 4'h0;
    logic [31:0]      wb_dat_i = 32'h0000_0000;
    logic [31:0]      wb_dat_o;
    logic             wb_ack_o;
    logic             core_sp_load = 1'b0;
    logic [7:0]       core_sp_val = 8'h00;
    cioc_evt_s        unit_evt = '0;
    logic             pin0 = 1'b0;
    logic             pin4 = 1'b0;
    logic [2:0]       osc_tap = 3'h0;
    logic [7:0]       stack_ptr;
    cioc_osc_s        osc_ctrl;
    cioc_clk_s        sys_clk_sel;
    logic [15:0]      wide_count;
    logic             irq;
    int               err_count = 0;
    int               comparisons = 0;
    int               cycles = 0;
    logic [7:0]       rnd = 8'h25;
    logic [7:0]       cm;
    logic [7:0]       ck;
    logic [31:0]      rd;
    logic [31:0]      hi;
    logic [15:0]      w0;

    cioc_regs cioc_regs_i (
        .sys_clk         (sys_clk),
        .reset_n         (reset_n),
        .wb_cyc_i        (wb_cyc_i),
        .wb_stb_i        (wb_stb_i),
        .wb_we_i         (wb_we_i),
        .wb_adr_i        (wb_adr_i),
        .wb_sel_i        (wb_sel_i),
        .wb_dat_i        (wb_dat_i),
        .wb_dat_o        (wb_dat_o),
        .wb_ack_o        (wb_ack_o),
        .core_sp_load    (core_sp_load),
        .core_sp_val     (core_sp_val),
        .unit_evt        (unit_evt),
        .port_a_pin_zero (pin0),
        .port_a_pin_four (pin4),
        .fast_rc_osc     (osc_tap[0]),
        .slow_rc_osc     (osc_tap[1]),
        .crystal_osc     (osc_tap[2]),
        .stack_ptr       (stack_ptr),
        .osc_ctrl        (osc_ctrl),
        .sys_clk_sel     (sys_clk_sel),
        .wide_count      (wide_count),
        .irq             (irq)
    );

    always #20 sys_clk = ~sys_clk;

    // ==========================================================
    // Helpers.
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic [7:0] clk_exp(input logic [7:0] c, input logic [7:0] prev);
        case ({c[3], c[7:5]})
            4'h0: return 8'h04;
            4'h1: return 8'h02;
            4'h6: return 8'h84;
            4'h7: return 8'h81;
            4'h8: return 8'h10;
            4'h9: return 8'h08;
            4'ha: return 8'h90;
            4'hb: return 8'h20;
            4'hc: return 8'h40;
            default: return prev;
        endcase
    endfunction

    function automatic logic [2:0] src_code(input int s);
        case (s)
            0: return T16_FAST;
            1: return T16_SLOW;
            2: return T16_XTAL;
            3: return T16_PA4;
            default: return T16_PA0;
        endcase
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h00_0000, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) err_count++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rdchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        check(name, q, {24'h00_0000, exp});
    endtask

    task automatic pulse(input int k);
        @(posedge sys_clk);
        unit_evt <= cioc_evt_s'(3'h1 << k);
        @(posedge sys_clk);
        unit_evt <= '0;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    // ==========================================================
    // Main sequence.
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rdchk("sp", IDX_SP, 8'h00);
        rdchk("clkmd", IDX_CLKMD, 8'hf6);
        rdchk("inten", IDX_INTEN, 8'h00);
        rdchk("intrq", IDX_INTRQ, 8'h00);
        rdchk("wide_timer_config", IDX_WIDE_TIMER_CONFIG, 8'h00);
        rdchk("unmapped", 8'h07, 8'h00);
        check("osc", osc_ctrl, 32'h0000_000e);
        check("ck", sys_clk_sel, 32'h0000_0081);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wr(IDX_SP, rnd);
            rdchk("sp", IDX_SP, rnd);
        end
        @(posedge sys_clk);
        core_sp_load <= 1'b1;
        core_sp_val  <= ~rnd;
        @(posedge sys_clk);
        core_sp_load <= 1'b0;
        rdchk("sp_core", IDX_SP, ~rnd);
        check("sp_port", stack_ptr, {24'h00_0000, ~rnd});
        $display("test stack done");
        ck = 8'h81;
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            cm = {i[2:0], rnd[4], i[3], rnd[2:0]};
            wr(IDX_CLKMD, cm);
            rdchk("clkmd", IDX_CLKMD, cm);
            ck = clk_exp(cm, ck);
            check("ck", sys_clk_sel, {24'h00_0000, ck});
            check("osc", osc_ctrl, {28'h000_0000, cm[4], cm[2], cm[1] & cm[2], cm[0]});
        end
        $display("test clock done");
        wr(IDX_INTEN, 8'hff);
        rdchk("inten", IDX_INTEN, 8'h77);
        wr(IDX_INTEN, 8'h40);
        for (int k = 0; k < 3; k++) begin
            pulse(k);
            rdchk("intrq", IDX_INTRQ, 8'h10 << k);
            check("irq", irq, {31'h0, k == 2});
            wr(IDX_INTRQ, 8'hff);
            rdchk("intrq_clr", IDX_INTRQ, 8'h00);
        end
        @(posedge sys_clk);
        pin0 <= 1'b1;
        pin4 <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rdchk("intrq_pin", IDX_INTRQ, 8'h03);
        wr(IDX_INTRQ, 8'h01);
        rdchk("intrq_w1c", IDX_INTRQ, 8'h02);
        wr(IDX_INTRQ, 8'hff);
        $display("test irq done");
        for (int d = 0; d < 4; d++) begin
            wr(IDX_WIDE_TIMER_CONFIG, {T16_SYS, d[1:0], 3'h6});
            @(negedge sys_clk);
            w0 = wide_count;
            repeat (64) @(negedge sys_clk);
            check("ticks", wide_count - w0, 32'd64 >> (2 * d));
        end
        wr(IDX_WIDE_TIMER_CONFIG, {T16_OFF, 5'h00});
        bus(1'b0, IDX_CNTH, 8'h00, hi);
        bus(1'b0, IDX_CNTL, 8'h00, rd);
        check("cnt", {hi[7:0], rd[7:0]}, wide_count);
        repeat (64) @(negedge sys_clk);
        check("stopped", {hi[7:0], rd[7:0]}, wide_count);
        for (int s = 0; s < 5; s++) begin
            wr(IDX_WIDE_TIMER_CONFIG, {src_code(s), 5'h06});
            w0 = wide_count;
            repeat (4) begin
                repeat (6) @(posedge sys_clk);
                if (s < 3) begin
                    osc_tap[s] <= 1'b1;
                end else if (s == 3) begin
                    pin4 <= 1'b0;
                end else begin
                    pin0 <= 1'b0;
                end
                repeat (6) @(posedge sys_clk);
                if (s < 3) begin
                    osc_tap[s] <= 1'b0;
                end else if (s == 3) begin
                    pin4 <= 1'b1;
                end else begin
                    pin0 <= 1'b1;
                end
            end
            repeat (6) @(posedge sys_clk);
            check("src_ticks", wide_count - w0, 32'd4);
        end
        for (int s = 0; s < 2; s++) begin
            wr(IDX_WIDE_TIMER_CONFIG, {T16_SYS, 2'h0, s ? T16_NOBIT : 3'h0});
            wr(IDX_INTRQ, 8'hff);
            repeat (300) @(posedge sys_clk);
            rdchk("t16_evt", IDX_INTRQ, s ? 8'h00 : 8'h04);
        end
        $display("test timer done");
        results();
    end
endmodule
